// File: verilog/pdgc_pkg.sv
// Package for the post-divider and GO sequencer of the secondary clock controller.
// Assumes a single 125 MHz clock domain; the divider reference arrives as an enable.
package pdgc_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [31:0] PDGC_OFS_DIV    = 32'h029c0118;
  localparam logic [31:0] PDGC_OFS_CMD    = 32'h029c0138;
  localparam logic [31:0] PDGC_OFS_STAT   = 32'h029c013c;
  localparam logic [31:0] PDGC_OFS_ALN    = 32'h029c0140;
  localparam logic [31:0] PDGC_OFS_CHG    = 32'h029c0144;
  localparam logic [31:0] PDGC_OFS_CLKON  = 32'h029c0150;

  // ----------------------------------------------------------------
  // Field positions and codes
  // ----------------------------------------------------------------
  localparam int          PDGC_BIT_EN     = 15;
  localparam int          PDGC_BIT_FLAG   = 0;
  localparam int          PDGC_RATIO_W    = 5;
  localparam logic [4:0]  PDGC_RATIO_DIV2 = 5'h01;
  localparam logic [4:0]  PDGC_RATIO_DIV5 = 5'h04;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic        PDGC_RST_EN     = 1'b1;
  localparam logic [4:0]  PDGC_RST_RATIO  = 5'h01;
  localparam logic        PDGC_RST_GO     = 1'b0;
  localparam logic        PDGC_RST_ALN    = 1'b1;
  localparam logic        PDGC_RST_CHG    = 1'b0;
  localparam logic        PDGC_RST_ON     = 1'b1;

  // Last count of a full period of the divided clock, in reference enables
  localparam logic [2:0]  PDGC_DIV2_LAST  = 3'h1;
  localparam logic [2:0]  PDGC_DIV5_LAST  = 3'h4;

  // Register access request from the processor or the debug emulator
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } pdgc_req_type;

  // Register read answer
  typedef struct packed {
    logic        valid;
    logic [31:0] rdata;
  } pdgc_rsp_type;

  // Sequencer states
  typedef enum logic [1:0] {
    PDGC_IDLE  = 2'b00,
    PDGC_WAIT  = 2'b01,
    PDGC_APPLY = 2'b10
  } pdgc_state_type;

endpackage

// File: verilog/pdgc_divider.sv
// Divided clock generator running on reference enables.
// Assumes refTick pulses one cycle per reference edge; ratio may change mid-period on an unaligned switch.
`timescale 1ns/1ps
module pdgc_divider (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // Control
  input  wire logic       refTick,
  input  wire logic       enable,
  input  wire logic [4:0] ratio,
  input  wire logic       restart,
  // Output
  output logic            divClk,
  output logic            boundary
);
  import pdgc_pkg::*;

  logic [2:0] cnt_ff;
  logic [2:0] nxt_cnt;
  logic       clk_ff;
  logic       nxt_clk;
  wire  [2:0] lastCnt = (ratio == PDGC_RATIO_DIV5) ? PDGC_DIV5_LAST : PDGC_DIV2_LAST;
  // A count left beyond the end by an unaligned shrink wraps at once, not after a long low
  wire        atEnd   = refTick && (cnt_ff >= lastCnt);

  // Count reference ticks over a full period; high for the first half, rounded down (2 of 5 ticks when dividing by five)
  assign nxt_cnt  = (!enable || restart) ? 3'h0 : (atEnd ? 3'h0 : (refTick ? cnt_ff + 3'h1 : cnt_ff));
  assign nxt_clk  = enable && !restart && (nxt_cnt < ((lastCnt + 3'h1) >> 1));
  assign boundary = atEnd || !enable;

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_ff <= 3'h0;
      clk_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      clk_ff <= nxt_clk;
    end
  end

  assign divClk = clk_ff;

endmodule

// File: verilog/pll_divider_go_control.sv
// Post-divider and GO sequencer for the secondary clock controller.
// Assumes register requests come only from the processor core or the emulator port.
`timescale 1ns/1ps
module pll_divider_go_control (
  // Clock and resets
  input  wire logic                   clk,
  input  wire logic                   nrst,
  input  wire logic                   warmRstN,
  // Register port, processor core and emulator only
  input  wire pdgc_pkg::pdgc_req_type cpuReq,
  input  wire pdgc_pkg::pdgc_req_type emuReq,
  output pdgc_pkg::pdgc_rsp_type      regRsp,
  // Divider reference enable, one pulse per reference edge
  input  wire logic                   refTick,
  // Divided clock to the MAC and its status
  output logic                        dividedMacClock,
  output logic                        outputOnFlag
);
  import pdgc_pkg::*;

  // ----------------------------------------------------------------
  // Access selection
  // ----------------------------------------------------------------
  // Only the two trusted masters have ports at all; the core wins a tie
  // The losing emulator access is dropped, not queued, so it has to retry
  wire          useCpu  = cpuReq.valid;
  wire          reqVal  = cpuReq.valid || emuReq.valid;
  wire          reqWr   = useCpu ? cpuReq.write : emuReq.write;
  wire   [31:0] reqAdr  = useCpu ? cpuReq.addr  : emuReq.addr;
  wire   [31:0] reqDat  = useCpu ? cpuReq.wdata : emuReq.wdata;
  wire          wrOp    = reqVal && reqWr;
  wire          rdOp    = reqVal && !reqWr;
  wire          hitDiv  = reqAdr == PDGC_OFS_DIV;
  wire          hitCmd  = reqAdr == PDGC_OFS_CMD;
  wire          hitStat = reqAdr == PDGC_OFS_STAT;
  wire          hitAln  = reqAdr == PDGC_OFS_ALN;
  wire          hitChg  = reqAdr == PDGC_OFS_CHG;
  wire          hitOn   = reqAdr == PDGC_OFS_CLKON;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  // Software-visible fields, then sequencer state and retimed outputs
  logic           enable_ff;
  logic [4:0]     ratio_ff;
  logic           goBit_ff;
  logic           align_ff;
  logic           changed_ff;
  logic [4:0]     active_ff;
  logic           busy_ff;
  pdgc_state_type state_ff;
  pdgc_rsp_type   rsp_ff;
  logic           on_ff;
  logic           macClk_ff;

  logic           nxt_enable;
  logic [4:0]     nxt_ratio;
  logic           nxt_goBit;
  logic           nxt_align;
  logic           nxt_changed;
  logic [4:0]     nxt_active;
  logic           nxt_busy;
  pdgc_state_type nxt_state;
  pdgc_rsp_type   nxt_rsp;

  // Both power-on and warm reset bring every register back
  // Merged once here so that no flop can miss either reset
  wire            rstAllN = nrst && warmRstN;

  // Divider register write; only the documented fields are stored
  // Reserved ratio codes are stored as written and divide by two
  wire            wrDiv   = wrOp && hitDiv;
  wire   [4:0]    wrRatio = reqDat[PDGC_RATIO_W-1:0];
  assign nxt_enable = wrDiv ? reqDat[PDGC_BIT_EN] : enable_ff;
  assign nxt_ratio  = wrDiv ? wrRatio : ratio_ff;

  // Go command bit: one starts GO, zero only clears the stored bit
  // A one written while busy is stored but ignored by the sequencer
  wire            wrCmd   = wrOp && hitCmd;
  wire            goStart = wrCmd && reqDat[PDGC_BIT_FLAG];
  assign nxt_goBit  = wrCmd ? reqDat[PDGC_BIT_FLAG] : goBit_ff;

  // Align bit is writable, though software is expected to leave it
  // It is looked at only while a GO sits in the wait state
  assign nxt_align  = (wrOp && hitAln) ? reqDat[PDGC_BIT_FLAG] : align_ff;

  // ----------------------------------------------------------------
  // GO sequencer
  // ----------------------------------------------------------------
  wire            divBoundary;
  wire            applyNow;
  // Unaligned switch happens at once; aligned one waits for a period edge
  assign applyNow = (state_ff == PDGC_WAIT) && (!align_ff || divBoundary);

  // IDLE waits for GO with a pending change, WAIT for the switch point, and
  // APPLY keeps busy one more cycle so status never drops before the new ratio
  always_comb begin
    nxt_state  = state_ff;
    nxt_active = active_ff;
    nxt_busy   = busy_ff;
    case (state_ff)
      PDGC_IDLE: begin
        // Without a pending change GO leaves the clock alone
        if (goStart && changed_ff) begin
          nxt_state = PDGC_WAIT;
          nxt_busy  = 1'b1;
        end
      end
      PDGC_WAIT: begin
        // Take the ratio as it stands now, not as it was when GO was written
        if (applyNow) begin
          nxt_active = ratio_ff;
          nxt_state  = PDGC_APPLY;
        end
      end
      PDGC_APPLY: begin
        // One settle cycle so the counter has loaded the new ratio
        nxt_state = PDGC_IDLE;
        nxt_busy  = 1'b0;
      end
      default: begin
        nxt_state = PDGC_IDLE;
        nxt_busy  = 1'b0;
      end
    endcase
  end

  // A fresh differing write wins over the clear at apply time
  // Clearing it anyway would lose a change made while GO completes
  wire            ratioDiff = wrDiv && (wrRatio != ratio_ff);
  assign nxt_changed = ratioDiff ? 1'b1 : ((state_ff == PDGC_APPLY) ? 1'b0 : changed_ff);

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Reserved bits and unmapped addresses read as zero
  // Each word is built in full so a reserved bit cannot leak from a wider store
  wire   [31:0] rdDiv  = {16'h0000, enable_ff, 10'h000, ratio_ff};
  wire   [31:0] rdCmd  = {31'h00000000, goBit_ff};
  wire   [31:0] rdStat = {31'h00000000, busy_ff};
  wire   [31:0] rdAln  = {31'h00000000, align_ff};
  wire   [31:0] rdChg  = {31'h00000000, changed_ff};
  wire   [31:0] rdOn   = {31'h00000000, on_ff};
  wire   [31:0] rdVal  = hitDiv  ? rdDiv  :
                         hitCmd  ? rdCmd  :
                         hitStat ? rdStat :
                         hitAln  ? rdAln  :
                         hitChg  ? rdChg  :
                         hitOn   ? rdOn   : 32'h00000000;
  // Idle cycles answer with zeros so a stale word never sits on the port
  assign nxt_rsp.valid = rdOp;
  assign nxt_rsp.rdata = rdOp ? rdVal : 32'h00000000;

  // ----------------------------------------------------------------
  // Divider, fed by the halved PLL output as reference enable
  // ----------------------------------------------------------------
  // Restart only on an aligned switch; an unaligned one keeps the running count
  wire            divClkRaw;
  pdgc_divider u_divider (
    .clk      (clk),
    .nrst     (rstAllN),
    .refTick  (refTick),
    .enable   (enable_ff),
    .ratio    (active_ff),
    .restart  (applyNow && align_ff),
    .divClk   (divClkRaw),
    .boundary (divBoundary)
  );

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Control and status flops; all of them return to default on either reset
  always_ff @(posedge clk or negedge rstAllN) begin
    if (!rstAllN) begin
      enable_ff  <= PDGC_RST_EN;
      ratio_ff   <= PDGC_RST_RATIO;
      goBit_ff   <= PDGC_RST_GO;
      align_ff   <= PDGC_RST_ALN;
      changed_ff <= PDGC_RST_CHG;
      active_ff  <= PDGC_RST_RATIO;
      busy_ff    <= 1'b0;
      state_ff   <= PDGC_IDLE;
      rsp_ff     <= '0;
    end else begin
      enable_ff  <= nxt_enable;
      ratio_ff   <= nxt_ratio;
      goBit_ff   <= nxt_goBit;
      align_ff   <= nxt_align;
      changed_ff <= nxt_changed;
      active_ff  <= nxt_active;
      busy_ff    <= nxt_busy;
      state_ff   <= nxt_state;
      rsp_ff     <= nxt_rsp;
    end
  end

  // Output flag and clock are retimed so the top outputs come from flops
  // The one-cycle lag of the clock is the price of a glitch-free flop output
  always_ff @(posedge clk or negedge rstAllN) begin
    if (!rstAllN) begin
      on_ff     <= PDGC_RST_ON;
      macClk_ff <= 1'b0;
    end else begin
      on_ff     <= nxt_enable;
      macClk_ff <= divClkRaw && enable_ff;
    end
  end

  assign regRsp          = rsp_ff;
  assign dividedMacClock = macClk_ff;
  assign outputOnFlag    = on_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_gated_when_off: assert property (@(posedge clk) disable iff (!rstAllN)
    !enable_ff |=> !macClk_ff) else $error("divided clock runs while disabled");
  a_flag_follows_en: assert property (@(posedge clk) disable iff (!rstAllN)
    !enable_ff |-> !on_ff) else $error("output-on flag high while disabled");
  a_go_needs_change: assert property (@(posedge clk) disable iff (!rstAllN)
    (state_ff == PDGC_IDLE && goStart && !changed_ff) |=> !busy_ff)
    else $error("GO started without a pending ratio change");
  a_go_busy_set: assert property (@(posedge clk) disable iff (!rstAllN)
    (state_ff == PDGC_IDLE && goStart && changed_ff) |=> busy_ff)
    else $error("go-in-progress not raised");
  a_zero_no_go: assert property (@(posedge clk) disable iff (!rstAllN)
    (wrCmd && !reqDat[0]) |=> !goBit_ff && $stable(active_ff))
    else $error("writing zero to go bit had an effect");
  a_diff_sets_flag: assert property (@(posedge clk) disable iff (!rstAllN)
    ratioDiff |=> changed_ff) else $error("ratio change not flagged");
  a_unaligned_fast: assert property (@(posedge clk) disable iff (!rstAllN)
    (state_ff == PDGC_WAIT && !align_ff) |=> (active_ff == $past(ratio_ff)))
    else $error("unaligned GO did not switch at once");
  a_apply_clears: assert property (@(posedge clk) disable iff (!rstAllN)
    (state_ff == PDGC_APPLY && !ratioDiff) |=> !changed_ff && !busy_ff)
    else $error("GO completion did not clear status");
  a_reserved_zero: assert property (@(posedge clk) disable iff (!rstAllN)
    rsp_ff.valid |-> (rsp_ff.rdata[31:16] == 16'h0000))
    else $error("reserved read bits not zero");
  a_div_untouched: assert property (@(posedge clk) disable iff (!rstAllN)
    !wrDiv |=> ($stable(enable_ff) && $stable(ratio_ff)))
    else $error("divider fields changed without a divider write");
  a_idle_rdata_zero: assert property (@(posedge clk) disable iff (!rstAllN)
    !rdOp |=> (!rsp_ff.valid && rsp_ff.rdata == 32'h00000000))
    else $error("answer or data without a read");
  a_read_answer: assert property (@(posedge clk) disable iff (!rstAllN)
    rdOp |=> rsp_ff.valid)
    else $error("read not answered in the next cycle");
  a_go_bit_set: assert property (@(posedge clk) disable iff (!rstAllN)
    (wrCmd && reqDat[PDGC_BIT_FLAG]) |=> goBit_ff)
    else $error("go bit not stored");
  a_go_bit_holds: assert property (@(posedge clk) disable iff (!rstAllN)
    !wrCmd |=> $stable(goBit_ff))
    else $error("go bit changed without a command write");
  // Sequencer and status consistency
  a_busy_tracks_state: assert property (@(posedge clk) disable iff (!rstAllN)
    busy_ff == (state_ff != PDGC_IDLE))
    else $error("go-in-progress disagrees with the sequencer");
  a_state_legal: assert property (@(posedge clk) disable iff (!rstAllN)
    state_ff inside {PDGC_IDLE, PDGC_WAIT, PDGC_APPLY})
    else $error("sequencer in an unused state");
  a_on_mirrors_en: assert property (@(posedge clk) disable iff (!rstAllN)
    on_ff == enable_ff)
    else $error("output-on flag does not follow the enable");
  a_keep_outside_go: assert property (@(posedge clk) disable iff (!rstAllN)
    (state_ff != PDGC_WAIT) |=> $stable(active_ff))
    else $error("active ratio changed outside a GO");
  a_aligned_waits: assert property (@(posedge clk) disable iff (!rstAllN)
    (state_ff == PDGC_WAIT && align_ff && !divBoundary) |=> (state_ff == PDGC_WAIT))
    else $error("aligned GO switched away from a period edge");
  a_aligned_takes: assert property (@(posedge clk) disable iff (!rstAllN)
    (state_ff == PDGC_WAIT && align_ff && divBoundary) |=> (active_ff == $past(ratio_ff)))
    else $error("aligned GO did not take the programmed ratio");
  a_apply_one_cycle: assert property (@(posedge clk) disable iff (!rstAllN)
    (state_ff == PDGC_APPLY) |=> (state_ff == PDGC_IDLE))
    else $error("GO did not complete after the apply cycle");
  a_same_ratio_quiet: assert property (@(posedge clk) disable iff (!rstAllN)
    (state_ff == PDGC_IDLE && !ratioDiff) |=> (changed_ff == $past(changed_ff)))
    else $error("ratio-changed flag moved without a differing write");

endmodule

// File: bench/pdgc_mac_partner.sv
// Reference source and MAC-side clock consumer for the divider block.
// Assumes one clk domain; the PLL output is taken to run at the clk rate.
`timescale 1ns/1ps
module pdgc_mac_partner (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // Divided clock from the block
  input  wire logic       dividedMacClock,
  // Reference enable and measured period
  output logic            refTick,
  output logic [7:0]      lastPeriod
);
  logic       phase_ff;
  logic       macPrev_ff;
  logic [7:0] tickCnt_ff;
  wire        macRise = dividedMacClock & ~macPrev_ff;

  // Reference is the PLL output halved, so one tick every second cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phase_ff <= 1'b0;
      refTick  <= 1'b0;
    end else begin
      phase_ff <= ~phase_ff;
      refTick  <= phase_ff;
    end
  end

  // Ticks between rising edges; the count wraps while gated, which is harmless
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      macPrev_ff <= 1'b0;
      tickCnt_ff <= 8'h00;
      lastPeriod <= 8'h00;
    end else begin
      macPrev_ff <= dividedMacClock;
      if (macRise) begin
        lastPeriod <= tickCnt_ff;
        tickCnt_ff <= {7'h00, refTick};
      end else begin
        tickCnt_ff <= tickCnt_ff + {7'h00, refTick};
      end
    end
  end
endmodule

// File: bench/pll_divider_go_control_tb_top.sv
// Self-checking bench for the divider and GO sequencer.
// Assumes the partner model supplies refTick and measures the divided clock.
`timescale 1ns/1ps
module pll_divider_go_control_tb_top;
  import pdgc_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus and observation
  // ----------------------------------------------------------------
  logic         clk      = 1'b0;
  logic         nrst     = 1'b0;
  logic         warmRstN = 1'b1;
  pdgc_req_type cpuReq   = '0;
  pdgc_req_type emuReq   = '0;
  pdgc_rsp_type regRsp;
  logic         refTick;
  logic         dividedMacClock;
  logic         outputOnFlag;
  logic         seenHigh;
  logic [7:0]   lastPeriod;
  logic [31:0]  rnd;
  logic [31:0]  expQ[$];
  int           errTotal  = 0;
  int           numChecks = 0;

  always #4 clk = ~clk;

  pll_divider_go_control uut (.clk(clk), .nrst(nrst), .warmRstN(warmRstN), .cpuReq(cpuReq),
    .emuReq(emuReq), .regRsp(regRsp), .refTick(refTick), .dividedMacClock(dividedMacClock),
    .outputOnFlag(outputOnFlag));
  pdgc_mac_partner mac (.clk(clk), .nrst(nrst), .dividedMacClock(dividedMacClock),
    .refTick(refTick), .lastPeriod(lastPeriod));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic ok, input string msg);
    numChecks++;
    if (ok !== 1'b1) begin
      errTotal++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  // One access; for a read, d is the expected word and is noted in the queue
  task automatic acc(input logic emu, input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    if (emu) emuReq <= '{1'b1, w, a, d};
    else cpuReq <= '{1'b1, w, a, d};
    if (!w) expQ.push_back(d);
    @(posedge clk);
    cpuReq <= '0;
    emuReq <= '0;
  endtask

  // Let the new ratio settle, then compare the measured period in ticks
  task automatic per(input logic [7:0] n);
    repeat (40) @(posedge clk);
    chk(lastPeriod === n, "divided clock period");
  endtask

  task automatic endT(input string n);
    $display("test %s finished", n);
  endtask

  task automatic tallyAndFinish;
    if (expQ.size() != 0) begin
      errTotal++;
      $display("CHECK FAILED at %0t: %0d reads never answered", $time, expQ.size());
    end
    $display("checks %0d mismatches %0d", numChecks, errTotal);
    if (errTotal == 0 && numChecks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Read answers stand one cycle; each one retires the oldest note
  always @(posedge clk) begin
    if (regRsp.valid === 1'b1) begin
      if (expQ.size() == 0) chk(1'b0, "answer without a read");
      else chk(regRsp.rdata === expQ.pop_front(), "read data");
    end
  end

  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #40000;
    errTotal++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    tallyAndFinish();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    rnd = $urandom(17);
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    acc(0, 0, PDGC_OFS_DIV, 32'h00008001);
    acc(0, 0, PDGC_OFS_CMD, 32'h0);
    acc(0, 0, PDGC_OFS_STAT, 32'h0);
    acc(0, 0, PDGC_OFS_ALN, 32'h1);
    acc(0, 0, PDGC_OFS_CHG, 32'h0);
    acc(0, 0, PDGC_OFS_CLKON, 32'h1);
    // Reserved addresses are only ever read here, never written
    acc(0, 0, 32'h029c0148, 32'h0);
    per(8'd2);
    endT("reset values");
    rnd = $urandom();
    acc(0, 1, PDGC_OFS_DIV, {rnd[31:16], 1'b1, rnd[14:5], PDGC_RATIO_DIV5});
    acc(0, 0, PDGC_OFS_DIV, 32'h00008004);
    acc(0, 0, PDGC_OFS_CHG, 32'h1);
    acc(0, 1, PDGC_OFS_CMD, 32'h1);
    // Software waits out the GO before looking again
    repeat (60) @(posedge clk);
    acc(0, 0, PDGC_OFS_STAT, 32'h0);
    acc(0, 0, PDGC_OFS_CHG, 32'h0);
    acc(0, 0, PDGC_OFS_CMD, 32'h1);
    per(8'd5);
    endT("aligned go");
    acc(0, 1, PDGC_OFS_DIV, 32'h00008001);
    acc(0, 1, PDGC_OFS_CMD, 32'h0);
    acc(0, 0, PDGC_OFS_STAT, 32'h0);
    acc(0, 0, PDGC_OFS_CMD, 32'h0);
    acc(0, 0, PDGC_OFS_CHG, 32'h1);
    per(8'd5);
    endT("go bit cleared");
    // Align is turned off on purpose, the only way to reach the unaligned switch
    rnd = $urandom();
    acc(0, 1, PDGC_OFS_ALN, {rnd[31:1], 1'b0});
    acc(0, 0, PDGC_OFS_ALN, 32'h0);
    acc(0, 1, PDGC_OFS_CMD, 32'h1);
    acc(0, 0, PDGC_OFS_STAT, 32'h1);
    acc(0, 0, PDGC_OFS_CHG, 32'h0);
    per(8'd2);
    acc(0, 1, PDGC_OFS_DIV, 32'h00008004);
    acc(0, 1, PDGC_OFS_CMD, 32'h1);
    acc(0, 0, PDGC_OFS_STAT, 32'h1);
    per(8'd5);
    acc(0, 1, PDGC_OFS_CMD, 32'h1);
    acc(0, 0, PDGC_OFS_STAT, 32'h0);
    per(8'd5);
    endT("unaligned go");
    acc(0, 1, PDGC_OFS_DIV, 32'h00000004);
    acc(0, 0, PDGC_OFS_CLKON, 32'h0);
    chk(outputOnFlag === 1'b0, "flag while gated");
    seenHigh = 1'b0;
    repeat (30) @(posedge clk) seenHigh = seenHigh | dividedMacClock;
    chk(seenHigh === 1'b0, "clock while gated");
    acc(0, 1, PDGC_OFS_DIV, 32'h00008004);
    acc(0, 0, PDGC_OFS_CLKON, 32'h1);
    chk(outputOnFlag === 1'b1, "flag while running");
    per(8'd5);
    endT("gating");
    // Align goes back to its default, where software is to leave it
    acc(1, 1, PDGC_OFS_ALN, 32'h1);
    acc(1, 0, PDGC_OFS_ALN, 32'h1);
    // Emulator write loses to a processor read in the same cycle
    @(posedge clk);
    cpuReq <= '{1'b1, 1'b0, PDGC_OFS_CLKON, 32'h1};
    emuReq <= '{1'b1, 1'b1, PDGC_OFS_ALN, 32'h0};
    expQ.push_back(32'h1);
    @(posedge clk);
    cpuReq <= '0;
    emuReq <= '0;
    acc(0, 0, PDGC_OFS_ALN, 32'h1);
    endT("emulator port");
    acc(0, 1, PDGC_OFS_ALN, 32'h0);
    acc(0, 1, PDGC_OFS_CMD, 32'h0);
    warmRstN <= 1'b0;
    repeat (3) @(posedge clk);
    warmRstN <= 1'b1;
    acc(0, 0, PDGC_OFS_DIV, 32'h00008001);
    acc(0, 0, PDGC_OFS_ALN, 32'h1);
    acc(0, 0, PDGC_OFS_CLKON, 32'h1);
    per(8'd2);
    endT("warm reset");
    repeat (4) @(posedge clk);
    tallyAndFinish();
  end
endmodule
